/* File: hw/pcf_cfg_space.sv */
// pcf_cfg_space: function-0 configuration header target, decode and storage
// assumes: pci clock and reset; bus front end supplies decoded phases
`timescale 1ns/100ps
// Overview of operation
// - two-function type 0 target; function 0 reports multimedia video class.
// - address bits 10:8 select function; only 000 reaches these registers.
// - claim only with idsel high and address bits 1:0 equal 00.
// - bursts advance one dword per data phase, reads and writes.
// - writes to reserved or read-only bits complete normally, data dropped.
// - reads of reserved or unimplemented bits return zero, complete normally.
// - select register by address bits 7:2 and byte enables.
// - registers are dwords addressed by byte; small fields sit in any lane.
// - configuration space reachable always, regardless of command enables.
// - cis pointer, bist, cache line, rom base and user features unimplemented.
// - implement the 64-byte predefined header of function 0.
// - read-only fields return fixed defaults; writes ignored.
// - read/write fields clear to zero on bus reset unless stated.
// - differing-readback fields take writes like ordinary read/write fields.
// - write-one-to-clear status bits clear on 1, keep on 0.
// - command zero blocks memory and master activity, not configuration.
// - detected parity error sets on any parity error, regardless of enable.
module pcf_cfg_space (
    // clock and reset
    input  wire logic                 I_MCLK,
    input  wire logic                 I_RSTN,
    // bus phases
    input  wire pcf_pkg::pcf_addr_t   I_ADDR,
    input  wire pcf_pkg::pcf_data_t   I_DATA,
    input  wire logic                 I_FRAME_END,
    // hardware events
    input  wire pcf_pkg::pcf_events_t I_EVENTS,
    // answers
    output logic                      O_CLAIM,
    output logic [31:0]               O_RDATA,
    output logic                      O_MEM_EN,
    output logic                      O_MASTER_EN,
    output logic                      O_PERR_EN,
    output logic                      O_SERR_EN,
    output logic [19:0]               O_BASE0
);
    import pcf_pkg::*;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        merge = (old_v & ~lane_mask(be)) | (new_v & lane_mask(be));
    endfunction : merge

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_DATA = 2'b10
    } pcf_state_t;

    pcf_state_t  state_q, state_d;
    logic [5:0]  idx_q, idx_d;
    logic        wr_q, wr_d;
    logic [10:0] cmd_q, cmd_d;
    logic [5:0]  stat_q, stat_d;
    logic [5:0]  w1c;
    logic        wr_phase;
    logic [7:0]  lat_q, lat_d;
    logic [19:0] base0_q, base0_d;
    logic [7:0]  intline_q, intline_d;
    logic [31:0] rdata_q, rdata_d;
    logic        hit;
    logic [31:0] rd_word;
    logic [31:0] cur;
    logic [31:0] wv;

    // ----------------------------------------------------------------
    // address phase decode
    // ----------------------------------------------------------------
    // no command bit gates this path, so config is always reachable
    assign hit = I_ADDR.frame && I_ADDR.cfg_cmd && I_ADDR.idsel
               && (I_ADDR.ad[1:0] == CFG_TYPE0)
               && (I_ADDR.ad[10:8] == FUNC_SEL0);

    // ----------------------------------------------------------------
    // read word assembly
    // ----------------------------------------------------------------
    always_comb begin
        cur = 32'h0000_0000;
        case (idx_q)
            OFF_ID:       cur = {DEVICE_DEF, VENDOR_DEF};
            OFF_CMDSTAT:  cur = {stat_q[ST_DPE], stat_q[ST_SSE], stat_q[ST_RMA], stat_q[ST_RTA],
                                 stat_q[ST_STA], DEVSEL_TIME, stat_q[ST_DPR], FB2B_CAP, 7'h00,
                                 5'h00, cmd_q};
            OFF_CLASSREV: cur = {CLASS_DEF, REVISION_DEF};
            OFF_HDRLAT:   cur = {8'h00, HDRTYPE_DEF, lat_q, 8'h00};
            OFF_BASE0:    cur = {base0_q, BASE0_LOW};
            OFF_SUBSYS:   cur = {SUBSYS_DEF, SUBVEN_DEF};
            OFF_INTLINE:  cur = {16'h0000, INTPIN_DEF, intline_q};
            default:      cur = 32'h0000_0000;
        endcase
        rd_word = cur;
    end

    // ----------------------------------------------------------------
    // status flags: write-one clear, hardware set wins
    // ----------------------------------------------------------------
    assign wr_phase = (state_q == S_DATA) && wr_q && I_DATA.valid;

    always_comb begin
        w1c = 6'h00;
        if (wr_phase && (idx_q == OFF_CMDSTAT) && I_DATA.be[3]) begin
            w1c[ST_DPR] = I_DATA.wdata[24];
            w1c[ST_STA] = I_DATA.wdata[27];
            w1c[ST_RTA] = I_DATA.wdata[28];
            w1c[ST_RMA] = I_DATA.wdata[29];
            w1c[ST_SSE] = I_DATA.wdata[30];
            w1c[ST_DPE] = I_DATA.wdata[31];
        end
        stat_d         = stat_q & ~w1c;
        stat_d[ST_DPE] = stat_d[ST_DPE] | I_EVENTS.det_parity;
        stat_d[ST_SSE] = stat_d[ST_SSE] | I_EVENTS.sig_serr;
        stat_d[ST_RMA] = stat_d[ST_RMA] | I_EVENTS.rcv_mabort;
        stat_d[ST_RTA] = stat_d[ST_RTA] | I_EVENTS.rcv_tabort;
        stat_d[ST_STA] = stat_d[ST_STA] | I_EVENTS.sig_tabort;
        stat_d[ST_DPR] = stat_d[ST_DPR] | (I_EVENTS.data_parity & cmd_q[CMD_PERR]);
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            stat_q <= STAT_RST;
        end else begin
            stat_q <= stat_d;
        end
    end

    // ----------------------------------------------------------------
    // transaction and register next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        idx_d     = idx_q;
        wr_d      = wr_q;
        cmd_d     = cmd_q;
        lat_d     = lat_q;
        base0_d   = base0_q;
        intline_d = intline_q;
        rdata_d   = rdata_q;
        wv        = merge(rd_word, I_DATA.wdata, I_DATA.be);
        case (state_q)
            S_IDLE: begin
                if (hit) begin
                    state_d = S_DATA;
                    idx_d   = I_ADDR.ad[7:2];
                    wr_d    = I_ADDR.write;
                    rdata_d = 32'h0000_0000;
                end
            end
            S_DATA: begin
                if (I_DATA.valid) begin
                    if (wr_q) begin
                        // only listed writable bits land; all else is dropped
                        case (idx_q)
                            OFF_CMDSTAT: cmd_d = wv[10:0] & 11'h146;
                            OFF_HDRLAT:  lat_d = wv[15:8];
                            OFF_BASE0:   base0_d = wv[31:12];
                            OFF_INTLINE: intline_d = wv[7:0];
                            default:     cmd_d = cmd_q;
                        endcase
                    end else begin
                        rdata_d = rd_word;
                    end
                    idx_d = idx_q + 6'h01;
                end
                if (I_FRAME_END) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            state_q   <= S_IDLE;
            idx_q     <= 6'h00;
            wr_q      <= 1'b0;
            cmd_q     <= CMD_RST;
            lat_q     <= LAT_RST;
            base0_q   <= BASE0_RST;
            intline_q <= INTLINE_RST;
            rdata_q   <= 32'h0000_0000;
        end else begin
            state_q   <= state_d;
            idx_q     <= idx_d;
            wr_q      <= wr_d;
            cmd_q     <= cmd_d;
            lat_q     <= lat_d;
            base0_q   <= base0_d;
            intline_q <= intline_d;
            rdata_q   <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign O_CLAIM     = (state_q == S_DATA);
    assign O_RDATA     = rdata_q;
    assign O_MEM_EN    = cmd_q[CMD_MEM];
    assign O_MASTER_EN = cmd_q[CMD_MAST];
    assign O_PERR_EN   = cmd_q[CMD_PERR];
    assign O_SERR_EN   = cmd_q[CMD_SERR];
    assign O_BASE0     = base0_q;

endmodule : pcf_cfg_space

/* File: hw/pcf_pkg.sv */
// pcf_pkg: constants and carrier types for the function-0 configuration header
// assumes: included before hw/pcf_cfg_space.sv
package pcf_pkg;

    // ----------------------------------------------------------------
    // header offsets (dword index = byte address [7:2])
    // ----------------------------------------------------------------
    localparam logic [5:0]  OFF_ID       = 6'h00;
    localparam logic [5:0]  OFF_CMDSTAT  = 6'h01;
    localparam logic [5:0]  OFF_CLASSREV = 6'h02;
    localparam logic [5:0]  OFF_HDRLAT   = 6'h03;
    localparam logic [5:0]  OFF_BASE0    = 6'h04;
    localparam logic [5:0]  OFF_SUBSYS   = 6'h0b;
    localparam logic [5:0]  OFF_INTLINE  = 6'h0f;
    localparam logic [5:0]  HDR_LAST     = 6'h0f;
    localparam logic [2:0]  FUNC_SEL0    = 3'h0;
    localparam logic [1:0]  CFG_TYPE0    = 2'h0;

    // ----------------------------------------------------------------
    // fixed values and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] VENDOR_DEF   = 16'h1234;   // arbitrary value
    localparam logic [15:0] DEVICE_DEF   = 16'h5678;   // arbitrary value
    localparam logic [7:0]  REVISION_DEF = 8'h01;      // arbitrary value
    localparam logic [15:0] SUBVEN_DEF   = 16'h0000;   // arbitrary value
    localparam logic [15:0] SUBSYS_DEF   = 16'h0000;   // arbitrary value
    localparam logic [23:0] CLASS_DEF    = 24'h040000;
    localparam logic [7:0]  HDRTYPE_DEF  = 8'h80;
    localparam logic [11:0] BASE0_LOW    = 12'h008;
    localparam logic [1:0]  DEVSEL_TIME  = 2'h1;
    localparam logic        FB2B_CAP     = 1'b1;
    localparam logic [7:0]  INTPIN_DEF   = 8'h01;
    localparam logic [10:0] CMD_RST      = 11'h000;
    localparam logic [5:0]  STAT_RST     = 6'h00;
    localparam logic [7:0]  LAT_RST      = 8'h00;
    localparam logic [19:0] BASE0_RST    = 20'h00000;
    localparam logic [7:0]  INTLINE_RST  = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CMD_MEM   = 1;
    localparam int CMD_MAST  = 2;
    localparam int CMD_PERR  = 6;
    localparam int CMD_SERR  = 8;
    localparam int ST_DPR    = 0;   // status bit 24
    localparam int ST_STA    = 1;   // 27
    localparam int ST_RTA    = 2;   // 28
    localparam int ST_RMA    = 3;   // 29
    localparam int ST_SSE    = 4;   // 30
    localparam int ST_DPE    = 5;   // 31

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        frame;     // address phase strobe
        logic        idsel;
        logic        cfg_cmd;   // command is config read or write
        logic        write;
        logic [31:0] ad;
    } pcf_addr_t;

    typedef struct packed {
        logic        valid;     // data phase completes this cycle
        logic [3:0]  be;        // active high byte enables
        logic [31:0] wdata;
    } pcf_data_t;

    typedef struct packed {
        logic det_parity;
        logic sig_serr;
        logic rcv_mabort;
        logic rcv_tabort;
        logic sig_tabort;
        logic data_parity;
    } pcf_events_t;

endpackage : pcf_pkg

/* File: verification/pcf_cfg_monitor.sv */
// pcf_cfg_monitor: assertions on the config target ports
// assumes: bound to pcf_cfg_space, one clock domain
`timescale 1ns/100ps
module pcf_cfg_monitor (
    // clock and reset
    input wire logic                I_MCLK,
    input wire logic                I_RSTN,
    // target inputs
    input wire pcf_pkg::pcf_addr_t  I_ADDR,
    input wire pcf_pkg::pcf_data_t  I_DATA,
    input wire logic                I_FRAME_END,
    input wire pcf_pkg::pcf_events_t I_EVENTS,
    // target outputs
    input wire logic                O_CLAIM,
    input wire logic [31:0]         O_RDATA,
    input wire logic                O_MEM_EN,
    input wire logic                O_MASTER_EN,
    input wire logic                O_PERR_EN,
    input wire logic                O_SERR_EN,
    input wire logic [19:0]         O_BASE0
);
    import pcf_pkg::*;
    // ----
    // dword index tracking
    // ----
    logic [5:0] idx_q, idx_d;
    logic       wr_q, wr_d, hit, ph;
    always_comb begin
        hit = I_ADDR.frame && I_ADDR.cfg_cmd && I_ADDR.idsel && I_ADDR.ad[1:0] == CFG_TYPE0
              && I_ADDR.ad[10:8] == FUNC_SEL0 && !O_CLAIM;
        ph = O_CLAIM && I_DATA.valid;
        idx_d = hit ? I_ADDR.ad[7:2] : idx_q + 6'(ph);
        wr_d = hit ? I_ADDR.write : wr_q;
    end
    always_ff @(posedge I_MCLK) begin
        idx_q <= idx_d;
        wr_q <= wr_d;
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // ----
    // checks
    // ----
    claim_on_hit_a: assert property (
        hit |=> O_CLAIM) else $error("claim missing");
    miss_ignored_a: assert property (
        !O_CLAIM && !hit |=> !O_CLAIM) else $error("cycle claimed wrongly");
    claim_end_a: assert property (
        O_CLAIM && I_FRAME_END |=> !O_CLAIM) else $error("claim not ended");
    reset_clear_a: assert property (
        $rose(I_RSTN) |-> !O_CLAIM && O_RDATA == 32'h0 && O_BASE0 == 20'h0 && !O_SERR_EN)
        else $error("outputs not cleared");
    id_read_a: assert property (
        ph && !wr_q && idx_q == OFF_ID |=> O_RDATA == {DEVICE_DEF, VENDOR_DEF}) else $error("bad id");
    unimpl_zero_a: assert property (
        ph && !wr_q && idx_q > OFF_BASE0 && idx_q != OFF_SUBSYS && idx_q != OFF_INTLINE |=> O_RDATA == 32'h0)
        else $error("unimplemented not zero");
    cmd_write_a: assert property (
        ph && wr_q && idx_q == OFF_CMDSTAT && I_DATA.be[0]
        |=> O_MEM_EN == $past(I_DATA.wdata[1]) && O_MASTER_EN == $past(I_DATA.wdata[2]))
        else $error("command not written");
    quiet_regs_a: assert property (
        !(ph && wr_q) |=> $stable(O_BASE0) && $stable(O_SERR_EN) && $stable(O_PERR_EN))
        else $error("register changed without write");
    cover property (hit ##1 O_CLAIM);
    cover property (ph && !wr_q ##1 ph);
    cover property (I_EVENTS.det_parity);
endmodule : pcf_cfg_monitor

/* File: verification/pcf_host_model.sv */
// pcf_host_model: host bridge issuing type 0 configuration cycles
// assumes: drives target inputs just after the rising clock edge
`timescale 1ns/100ps
module pcf_host_model (
    // clock and answers
    input  wire logic [0:0]  i_clk,
    input  wire logic [31:0] i_rdata,
    // bus phases
    output pcf_pkg::pcf_addr_t o_addr,
    output pcf_pkg::pcf_data_t o_data,
    output logic               o_end
);
    import pcf_pkg::*;
    logic [31:0] wq [4];
    logic [31:0] rq [4];
    initial begin
        o_addr = '0;
        o_data = '0;
        o_end = 1'b0;
    end
    // ----
    // address phase then n data phases; released lines show inverse
    // ----
    task automatic xfer(input logic [31:0] ad, input logic wr, input logic [3:0] be, input int n, input logic sel);
        int k;
        @(posedge i_clk) #1;
        o_addr = '{1'b1, sel, 1'b1, wr, ad};
        @(posedge i_clk) #1;
        o_addr = '{1'b0, 1'b0, 1'b0, 1'b0, ~ad};
        for (k = 0; k < n; k++) begin
            o_data = '{1'b1, be, wq[k]};
            o_end = (k == n - 1);
            @(posedge i_clk) #1;
            rq[k] = i_rdata;
        end
        o_data = '{1'b0, ~be, ~wq[n - 1]};
        o_end = 1'b0;
    endtask : xfer
endmodule : pcf_host_model

/* File: verification/testbench.sv */
// testbench: self-checking bench for pcf_cfg_space
// assumes: host model drives the bus, bench drives reset and events
`timescale 1ns/100ps
module testbench;
    import pcf_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    pcf_events_t ev = '0;
    pcf_addr_t   addr;
    pcf_data_t   data;
    logic        fend, claim, mem_en, mst_en, perr_en, serr_en;
    logic        claim_seen = 1'b0;
    logic [31:0] rdata;
    logic [19:0] base0;
    int          fails = 0;
    int          check_count = 0;
    localparam logic [31:0] ST = {5'h0, DEVSEL_TIME, 1'b0, FB2B_CAP, 23'h0};
    logic [31:0] rows [17] = '{{DEVICE_DEF, VENDOR_DEF}, ST, {CLASS_DEF, REVISION_DEF},
        {8'h0, HDRTYPE_DEF, LAT_RST, 8'h0}, {BASE0_RST, BASE0_LOW}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, {SUBSYS_DEF, SUBVEN_DEF}, 32'h0, 32'h0, 32'h0, {16'h0, INTPIN_DEF, INTLINE_RST}, 32'h0};
    always #25 mclk = ~mclk;
    always @(posedge mclk) if (claim === 1'b1) claim_seen <= 1'b1;
    pcf_host_model u_host (.i_clk(mclk), .i_rdata(rdata), .o_addr(addr), .o_data(data), .o_end(fend));
    pcf_cfg_space u_dut (.I_MCLK(mclk), .I_RSTN(rstn), .I_ADDR(addr), .I_DATA(data), .I_FRAME_END(fend),
        .I_EVENTS(ev), .O_CLAIM(claim), .O_RDATA(rdata), .O_MEM_EN(mem_en), .O_MASTER_EN(mst_en),
        .O_PERR_EN(perr_en), .O_SERR_EN(serr_en), .O_BASE0(base0));
    // ----
    // helpers
    // ----
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [5:0] i, input logic [3:0] be, input logic [31:0] d);
        u_host.wq[0] = d;
        u_host.xfer({24'h0, i, 2'h0}, 1'b1, be, 1, 1'b1);
    endtask : wr
    task automatic rd(input logic [5:0] i, input int n);
        u_host.xfer({24'h0, i, 2'h0}, 1'b0, 4'hf, n, 1'b1);
    endtask : rd
    task automatic pulse(input pcf_events_t e);
        @(posedge mclk) #1 ev = e;
        @(posedge mclk) #1 ev = '0;
    endtask : pulse
    task automatic tally_and_finish();
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // ----
    // tests
    // ----
    initial begin
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        for (int k = 0; k < 17; k++) begin
            rd(6'(k), 1);
            chk("reset word", rows[k], u_host.rq[0]);
        end
        wr(OFF_CMDSTAT, 4'hf, 32'hffff_ffff);
        chk("enables", 32'hf, {28'h0, serr_en, perr_en, mst_en, mem_en});
        rd(OFF_CMDSTAT, 1);
        chk("command", ST | 32'h146, u_host.rq[0]);
        wr(OFF_CMDSTAT, 4'h1, 32'h0);
        chk("lanes", 32'h8, {28'h0, serr_en, perr_en, mst_en, mem_en});
        wr(OFF_ID, 4'hf, 32'h0);
        u_host.wq = '{32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'h0};
        u_host.xfer({24'h0, OFF_HDRLAT, 2'h0}, 1'b1, 4'hf, 2, 1'b1);
        chk("base0 pin", 32'h000f_ffff, {12'h0, base0});
        rd(OFF_ID, 1);
        chk("id", rows[0], u_host.rq[0]);
        rd(OFF_HDRLAT, 2);
        chk("burst 0", {8'h0, HDRTYPE_DEF, 8'hff, 8'h0}, u_host.rq[0]);
        chk("burst 1", {20'hfffff, BASE0_LOW}, u_host.rq[1]);
        wr(OFF_INTLINE, 4'h3, 32'hffff_ffff);
        rd(OFF_INTLINE, 1);
        chk("interrupt line", {16'h0, INTPIN_DEF, 8'hff}, u_host.rq[0]);
        claim_seen = 1'b0;
        u_host.wq[0] = 32'h0;
        u_host.xfer(32'h4, 1'b1, 4'hf, 1, 1'b0);
        u_host.xfer(32'h5, 1'b1, 4'hf, 1, 1'b1);
        u_host.xfer(32'h104, 1'b1, 4'hf, 1, 1'b1);
        chk("refused", 32'h1, {30'h0, claim_seen, serr_en});
        pulse('1);
        rd(OFF_CMDSTAT, 1);
        chk("status set", 32'hfa80_0100, u_host.rq[0]);
        wr(OFF_CMDSTAT, 4'h8, 32'h8000_0000);
        rd(OFF_CMDSTAT, 1);
        chk("status clear", 32'h7a80_0100, u_host.rq[0]);
        wr(OFF_CMDSTAT, 4'h1, 32'h40);
        pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
        rd(OFF_CMDSTAT, 1);
        chk("parity reported", 32'h7b80_0140, u_host.rq[0]);
        // parity event lands in the same cycle as the clearing write
        fork
            wr(OFF_CMDSTAT, 4'h8, 32'h8000_0000);
            begin
                @(posedge mclk);
                pulse('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
            end
        join
        rd(OFF_CMDSTAT, 1);
        chk("set beats clear", 32'hfb80_0140, u_host.rq[0]);
        rstn = 1'b0;
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        chk("after reset", 32'h0, {11'h0, base0, serr_en});
        rd(OFF_CMDSTAT, 1);
        chk("status reset", ST, u_host.rq[0]);
        tally_and_finish();
    end
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule : testbench
bind pcf_cfg_space pcf_cfg_monitor u_mon (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_DATA(I_DATA),
    .I_FRAME_END(I_FRAME_END), .I_EVENTS(I_EVENTS), .O_CLAIM(O_CLAIM), .O_RDATA(O_RDATA), .O_MEM_EN(O_MEM_EN),
    .O_MASTER_EN(O_MASTER_EN), .O_PERR_EN(O_PERR_EN), .O_SERR_EN(O_SERR_EN), .O_BASE0(O_BASE0));
